/* core/rxeil_top.sv */
`timescale 1ns/100ps
`default_nettype none
module rxeil_top (
	// clock and reset
	input  wire  logic                          clk_i,
	input  wire  logic                          rst_i,
	// wishbone slave
	input  wire  logic                          wb_cyc_i,
	input  wire  logic                          wb_stb_i,
	input  wire  logic                          wb_we_i,
	input  wire  logic [3:0]                    wb_sel_i,
	input  wire  logic [7:0]                    wb_adr_i,
	input  wire  logic [31:0]                   wb_dat_i,
	output logic [31:0]                         wb_dat_o,
	output logic                                wb_ack_o,
	// error detector pulses, same clock
	input  wire  rxeil_pkg::rxeil_evt_t         evt_i,
	input  wire  logic                          ctrl_evt_i,
	input  wire  logic                          ctrl_is_a_i,
	input  wire  logic                          ctrl_is_f_i,
	input  wire  logic [rxeil_pkg::ST_A_W-1:0]  evt_a_i,
	// link side
	output logic                                irq_o,
	output logic                                sync_req_n_o,
	output logic                                realign_hold_o
);
	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	function automatic logic [31:0] merge_bytes(
		input logic [31:0] old_v,
		input logic [31:0] new_v,
		input logic [3:0]  sel
	);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (sel[i])
				r[i*8 +: 8] = new_v[i*8 +: 8];
		end
		return r;
	endfunction : merge_bytes

	function automatic logic [31:0] lane_mask(input logic [3:0] sel);
		logic [31:0] m;
		m = '0;
		for (int i = 0; i < 4; i++) begin
			if (sel[i])
				m[i*8 +: 8] = 8'hFF;
		end
		return m;
	endfunction : lane_mask

	// ---------------------------------------------------------------
	// bus front end
	// ---------------------------------------------------------------
	rxeil_pkg::rxeil_wb_req_t req;
	logic                     wr_stb;
	logic                     rd_stb;

	assign req.cyc = wb_cyc_i;
	assign req.stb = wb_stb_i;
	assign req.we  = wb_we_i;
	assign req.sel = wb_sel_i;
	assign req.adr = wb_adr_i;
	assign req.dat = wb_dat_i;

	// ack leaves the slave flop as is: a second stage would let the
	// still-held request be taken twice
	rxeil_wb_slave u_wb (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.req_i (req),
		.ack_o (wb_ack_o),
		.wr_o  (wr_stb),
		.rd_o  (rd_stb)
	);

	// ---------------------------------------------------------------
	// event mapping
	// ---------------------------------------------------------------
	logic [rxeil_pkg::ST_B_W-1:0] set_b;

	rxeil_evt_map u_map (
		.evt_i       (evt_i),
		.ctrl_evt_i  (ctrl_evt_i),
		.ctrl_is_a_i (ctrl_is_a_i),
		.ctrl_is_f_i (ctrl_is_f_i),
		.set_o       (set_b)
	);

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	logic [rxeil_pkg::ST_B_W-1:0] status_b;
	logic [rxeil_pkg::ST_A_W-1:0] status_a;
	logic [31:0]                  irq_enable;
	logic [31:0]                  reinit_enable;
	logic [31:0]                  wmask;
	logic                         wr_b;
	logic                         wr_a;
	logic                         wr_en;
	logic                         wr_re;

	assign wmask = lane_mask(wb_sel_i) & wb_dat_i;
	assign wr_b  = wr_stb & (wb_adr_i == rxeil_pkg::ADR_STATUS_B);
	assign wr_a  = wr_stb & (wb_adr_i == rxeil_pkg::ADR_STATUS_A);
	assign wr_en = wr_stb & (wb_adr_i == rxeil_pkg::ADR_IRQ_ENABLE);
	assign wr_re = wr_stb & (wb_adr_i == rxeil_pkg::ADR_REINIT_EN);

	// set wins over a write-one clear in the same cycle
	always_ff @(posedge clk_i) begin
		if (rst_i)
			status_b <= '0;
		else if (wr_b)
			status_b <= (status_b & ~wmask[rxeil_pkg::ST_B_W-1:0])
				| set_b;
		else
			status_b <= status_b | set_b;
	end

	// bit 0 of the companion register is reserved
	always_ff @(posedge clk_i) begin
		if (rst_i)
			status_a <= '0;
		else if (wr_a)
			status_a <= ((status_a & ~wmask[rxeil_pkg::ST_A_W-1:0])
				| evt_a_i) & 9'h1_FE;
		else
			status_a <= (status_a | evt_a_i) & 9'h1_FE;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			irq_enable <= rxeil_pkg::IRQ_EN_RESET;
		else if (wr_en)
			irq_enable <= merge_bytes(irq_enable, wb_dat_i, wb_sel_i)
				& rxeil_pkg::IRQ_EN_MASK;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			reinit_enable <= rxeil_pkg::REINIT_RESET;
		else if (wr_re)
			reinit_enable <= merge_bytes(reinit_enable, wb_dat_i,
				wb_sel_i) & rxeil_pkg::REINIT_MASK;
	end

	// ---------------------------------------------------------------
	// gating
	// ---------------------------------------------------------------
	logic [rxeil_pkg::ST_B_W-1:0] en_b;
	logic [rxeil_pkg::ST_B_W-1:0] re_b;
	logic [rxeil_pkg::ST_A_W-1:0] en_a;
	logic [rxeil_pkg::ST_A_W-1:0] re_a;
	logic                         next_irq;
	logic                         next_reinit;

	assign en_b = irq_enable[rxeil_pkg::EN_B_MSB:rxeil_pkg::EN_B_LSB];
	assign re_b = reinit_enable[rxeil_pkg::EN_B_MSB:rxeil_pkg::EN_B_LSB];
	assign en_a = irq_enable[rxeil_pkg::EN_A_MSB:0];
	assign re_a = reinit_enable[rxeil_pkg::EN_A_MSB:0];

	// a zero enable hides the bit from irq but it still logs
	assign next_irq = |(status_b & en_b) | |(status_a & en_a);

	// sync loss bypasses its reinit enable
	assign next_reinit = |(status_b & re_b) | |(status_a & re_a)
		| status_b[rxeil_pkg::BIT_SYNC_LOST];

	always_ff @(posedge clk_i) begin
		if (rst_i)
			irq_o <= 1'b0;
		else
			irq_o <= next_irq;
	end

	// active low request, held while any enabled bit stays logged
	always_ff @(posedge clk_i) begin
		if (rst_i)
			sync_req_n_o <= 1'b1;
		else
			sync_req_n_o <= ~next_reinit;
	end

	// alignment loss never realigns on the fly; lanes hold until its status bit is cleared
	always_ff @(posedge clk_i) begin
		if (rst_i)
			realign_hold_o <= 1'b0;
		else
			realign_hold_o <= status_b[rxeil_pkg::BIT_FRAME_ALIGN]
				| status_b[rxeil_pkg::BIT_LANE_ALIGN];
	end

	// ---------------------------------------------------------------
	// read data
	// ---------------------------------------------------------------
	logic [31:0] next_rdata;

	always_comb begin
		case (wb_adr_i)
			rxeil_pkg::ADR_STATUS_B:   next_rdata = {22'h0, status_b};
			rxeil_pkg::ADR_STATUS_A:   next_rdata = {23'h0, status_a};
			rxeil_pkg::ADR_IRQ_ENABLE: next_rdata = irq_enable;
			rxeil_pkg::ADR_REINIT_EN:  next_rdata = reinit_enable;
			default:                   next_rdata = '0;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			wb_dat_o <= '0;
		else if (rd_stb)
			wb_dat_o <= next_rdata;
	end
endmodule : rxeil_top
`default_nettype wire

/* inc/rxeil_pkg.sv */
package rxeil_pkg;
	// ---------------------------------------------------------------
	// register map (byte addresses)
	// ---------------------------------------------------------------
	localparam logic [7:0]  ADR_STATUS_B    = 8'h64;
	localparam logic [7:0]  ADR_IRQ_ENABLE  = 8'h74;
	localparam logic [7:0]  ADR_REINIT_EN   = 8'h78;
	localparam logic [7:0]  ADR_STATUS_A    = 8'h60;

	// ---------------------------------------------------------------
	// second error register fields
	// ---------------------------------------------------------------
	localparam int          ST_B_W          = 10;
	localparam int          ST_A_W          = 9;
	localparam int          BIT_SYNC_LOST   = 0;
	localparam int          BIT_FRAME_ALIGN = 1;
	localparam int          BIT_LANE_ALIGN  = 2;
	localparam int          BIT_STRAY_CTRL  = 3;
	localparam int          BIT_NOT_IN_TBL  = 4;
	localparam int          BIT_DISPARITY   = 5;
	localparam int          BIT_NO_ALIGN_SQ = 6;
	localparam int          BIT_SPARE       = 7;
	localparam int          BIT_ECC_FIXED   = 8;
	localparam int          BIT_ECC_FATAL   = 9;

	// ---------------------------------------------------------------
	// enable register layout
	// ---------------------------------------------------------------
	localparam int          EN_B_LSB        = 11;
	localparam int          EN_B_MSB        = 20;
	localparam int          EN_A_LSB        = 1;
	localparam int          EN_A_MSB        = 8;
	localparam logic [31:0] IRQ_EN_RESET    = 32'h0017_F9FE;
	localparam logic [31:0] IRQ_EN_MASK     = 32'h001F_F9FE;
	localparam logic [31:0] REINIT_RESET    = 32'h0000_0902;
	localparam logic [31:0] REINIT_MASK     = 32'h001F_F9FE;

	// ---------------------------------------------------------------
	// carriers
	// ---------------------------------------------------------------
	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [3:0]  sel;
		logic [7:0]  adr;
		logic [31:0] dat;
	} rxeil_wb_req_t;

	// msb first: member order matches the status bit positions
	typedef struct packed {
		logic        ecc_fatal;
		logic        ecc_fixed;
		logic        spare;
		logic        no_align_seq;
		logic        disparity;
		logic        not_in_table;
		logic        stray_ctrl;
		logic        lane_align;
		logic        frame_align;
		logic        sync_lost;
	} rxeil_evt_t;

	typedef enum logic [1:0] {
		WB_IDLE = 2'b01,
		WB_ACK  = 2'b10
	} rxeil_wb_st_t;
endpackage : rxeil_pkg

/* core/rxeil_evt_map.sv */
`timescale 1ns/100ps
`default_nettype none
module rxeil_evt_map (
	// detector pulses
	input  wire  rxeil_pkg::rxeil_evt_t          evt_i,
	input  wire  logic                           ctrl_evt_i,
	input  wire  logic                           ctrl_is_a_i,
	input  wire  logic                           ctrl_is_f_i,
	// status set vector
	output logic [rxeil_pkg::ST_B_W-1:0]         set_o
);
	// ---------------------------------------------------------------
	// map detector events to status bits
	// ---------------------------------------------------------------
	always_comb begin
		set_o = '0;
		set_o[rxeil_pkg::BIT_SYNC_LOST]   = evt_i.sync_lost;
		set_o[rxeil_pkg::BIT_FRAME_ALIGN] = evt_i.frame_align
			| (ctrl_evt_i & (ctrl_is_f_i | ctrl_is_a_i));
		set_o[rxeil_pkg::BIT_LANE_ALIGN]  = evt_i.lane_align
			| (ctrl_evt_i & ctrl_is_a_i);
		set_o[rxeil_pkg::BIT_STRAY_CTRL]  = evt_i.stray_ctrl
			| (ctrl_evt_i & ~ctrl_is_a_i & ~ctrl_is_f_i);
		set_o[rxeil_pkg::BIT_NOT_IN_TBL]  = evt_i.not_in_table;
		set_o[rxeil_pkg::BIT_DISPARITY]   = evt_i.disparity;
		set_o[rxeil_pkg::BIT_NO_ALIGN_SQ] = evt_i.no_align_seq;
		set_o[rxeil_pkg::BIT_SPARE]       = evt_i.spare;
		set_o[rxeil_pkg::BIT_ECC_FIXED]   = evt_i.ecc_fixed;
		set_o[rxeil_pkg::BIT_ECC_FATAL]   = evt_i.ecc_fatal;
	end
endmodule : rxeil_evt_map
`default_nettype wire

/* core/rxeil_wb_slave.sv */
`timescale 1ns/100ps
`default_nettype none
module rxeil_wb_slave (
	// clock and reset
	input  wire  logic                   clk_i,
	input  wire  logic                   rst_i,
	// bus side
	input  wire  rxeil_pkg::rxeil_wb_req_t req_i,
	output logic                         ack_o,
	// register side
	output logic                         wr_o,
	output logic                         rd_o
);
	// ---------------------------------------------------------------
	// one wait state, ack for one cycle per request
	// ---------------------------------------------------------------
	rxeil_pkg::rxeil_wb_st_t st;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st    <= rxeil_pkg::WB_IDLE;
			ack_o <= 1'b0;
		end else begin
			case (st)
				rxeil_pkg::WB_IDLE: begin
					ack_o <= req_i.cyc & req_i.stb;
					if (req_i.cyc & req_i.stb)
						st <= rxeil_pkg::WB_ACK;
				end
				rxeil_pkg::WB_ACK: begin
					ack_o <= 1'b0;
					st    <= rxeil_pkg::WB_IDLE;
				end
				default: begin
					ack_o <= 1'b0;
					st    <= rxeil_pkg::WB_IDLE;
				end
			endcase
		end
	end

	// strobes fire on the same edge that raises ack
	assign wr_o = (st == rxeil_pkg::WB_IDLE) & req_i.cyc & req_i.stb
		& req_i.we;
	assign rd_o = (st == rxeil_pkg::WB_IDLE) & req_i.cyc & req_i.stb
		& ~req_i.we;
endmodule : rxeil_wb_slave
`default_nettype wire

/* tb/rxeil_top_properties.sv */
`timescale 1ns/100ps
`default_nettype none
module rxeil_top_properties (
	// clock and reset
	input wire logic                  clk_i,
	input wire logic                  rst_i,
	// bus
	input wire logic                  wb_stb_i,
	input wire logic                  wb_we_i,
	input wire logic [7:0]            wb_adr_i,
	input wire logic [31:0]           wb_dat_i,
	input wire logic [31:0]           wb_dat_o,
	input wire logic                  wb_ack_o,
	// events and link
	input wire rxeil_pkg::rxeil_evt_t evt_i,
	input wire logic                  ctrl_evt_i,
	input wire logic                  ctrl_is_f_i,
	input wire logic                  irq_o,
	input wire logic                  sync_req_n_o,
	input wire logic                  realign_hold_o
);
	// shadow lags the real write by one edge; bench never fires then
	logic [31:0] en;
	always_ff @(posedge clk_i) begin
		if (rst_i)
			en <= rxeil_pkg::IRQ_EN_RESET;
		else if (wb_ack_o && wb_we_i &&
			wb_adr_i == rxeil_pkg::ADR_IRQ_ENABLE)
			en <= wb_dat_i & rxeil_pkg::IRQ_EN_MASK;
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_ack_walk;
		!wb_ack_o ##1 wb_ack_o ##1 !wb_ack_o;
	endsequence
	sequence s_wr_done;
		$past(wb_ack_o) && $past(wb_we_i);
	endsequence
	a_ack_walk: assert property ($rose(wb_stb_i) |-> s_ack_walk)
		else $error("ack timing wrong");
	a_sync_forced: assert property (
		evt_i.sync_lost |-> ##2 !sync_req_n_o) else $error("no reinit");
	a_irq_enabled: assert property (
		|(10'(evt_i) & en[20:11]) |-> ##2 irq_o) else $error("no irq");
	a_irq_sticky: assert property ($fell(irq_o) |-> s_wr_done)
		else $error("irq fell without write");
	a_sync_sticky: assert property (
		$rose(sync_req_n_o) |-> s_wr_done) else $error("sync released");
	a_hold_frame: assert property (
		evt_i.frame_align || (ctrl_evt_i && ctrl_is_f_i)
		|-> ##[1:2] realign_hold_o) else $error("no align hold");
	a_resv_zero: assert property (
		wb_ack_o && !wb_we_i && wb_adr_i == rxeil_pkg::ADR_STATUS_B
		|-> wb_dat_o[31:10] == '0) else $error("reserved status set");
	a_en_resv: assert property (
		wb_ack_o && !wb_we_i && wb_adr_i == rxeil_pkg::ADR_IRQ_ENABLE
		|-> (wb_dat_o & ~rxeil_pkg::IRQ_EN_MASK) == '0)
		else $error("reserved enable set");
	a_unmapped_zero: assert property (
		wb_ack_o && !wb_we_i &&
		!(wb_adr_i inside {8'h60, 8'h64, 8'h74, 8'h78})
		|-> wb_dat_o == '0) else $error("unmapped read nonzero");
endmodule : rxeil_top_properties
bind rxeil_top rxeil_top_properties i_rxeil_top_properties (.clk_i,
	.rst_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_dat_o,
	.wb_ack_o, .evt_i, .ctrl_evt_i, .ctrl_is_f_i, .irq_o, .sync_req_n_o,
	.realign_hold_o);
`default_nettype wire

/* tb/rxeil_top_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module rxeil_top_tb;
	localparam logic [7:0] A_SB = rxeil_pkg::ADR_STATUS_B;
	localparam logic [7:0] A_EN = rxeil_pkg::ADR_IRQ_ENABLE;
	localparam logic [7:0] A_RI = rxeil_pkg::ADR_REINIT_EN;
	localparam logic [7:0] A_SA = rxeil_pkg::ADR_STATUS_A;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic [3:0]  sel = 4'h0;
	logic [7:0]  adr = 8'h00;
	logic [31:0] dat = 32'h0000_0000;
	logic [9:0]  ev = 10'h000;
	logic [8:0]  ev_a = 9'h000;
	logic [2:0]  ctl = 3'h0;
	logic [31:0] rdat;
	logic [31:0] q;
	logic        ack;
	logic        irq;
	logic        sync_n;
	logic        hold;
	int          n_errors = 0;
	int          n_compared = 0;

	always #25 clk_i = ~clk_i;

	rxeil_top i_rxeil_top (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_sel_i(sel), .wb_adr_i(adr), .wb_dat_i(dat),
		.wb_dat_o(rdat), .wb_ack_o(ack),
		.evt_i(rxeil_pkg::rxeil_evt_t'(ev)), .ctrl_evt_i(ctl[2]),
		.ctrl_is_a_i(ctl[1]), .ctrl_is_f_i(ctl[0]), .evt_a_i(ev_a),
		.irq_o(irq), .sync_req_n_o(sync_n), .realign_hold_o(hold));

	// ----------------------------------------
	// bus and compare helpers
	// ----------------------------------------
	task give_verdict;
		$display("compared %0d mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : give_verdict

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task wb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		sel <= s;
		while (n < 20 && ack !== 1'b1) begin
			@(posedge clk_i);
			n++;
		end
		if (ack !== 1'b1) begin
			n_errors++;
			give_verdict();
		end
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : wb

	task wr(input logic [7:0] a, input logic [31:0] d);
		wb(1'b1, a, d, 4'hF);
	endtask : wr

	task rd(input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0000_0000, 4'hF);
		chk(q, e);
	endtask : rd

	task pins(input logic i, input logic s, input logic h);
		chk({29'h0, irq, sync_n, hold}, {29'h0, i, s, h});
	endtask : pins

	task fire(input logic [9:0] b, input logic [8:0] a, input logic [2:0] c);
		@(posedge clk_i);
		ev <= b;
		ev_a <= a;
		ctl <= c;
		@(posedge clk_i);
		ev <= 10'h000;
		ev_a <= 9'h000;
		ctl <= 3'h0;
		repeat (4) @(posedge clk_i);
	endtask : fire

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task t_reset;
		rd(A_EN, rxeil_pkg::IRQ_EN_RESET);
		rd(A_RI, rxeil_pkg::REINIT_RESET);
		rd(A_SB, 32'h0000_0000);
		wr(8'h10, 32'hFFFF_FFFF);
		rd(8'h10, 32'h0000_0000);
		pins(1'b0, 1'b1, 1'b0);
		$display("reset test done");
	endtask : t_reset

	task t_log;
		for (int i = 0; i < 10; i++) begin
			fire(10'h001 << i, 9'h000, 3'h0);
			rd(A_SB, 32'h0000_0001 << i);
			pins(i != 8, i != 0, i == 1 || i == 2);
			wr(A_SB, 32'h0000_0000);
			rd(A_SB, 32'h0000_0001 << i);
			wr(A_SB, 32'h0000_0001 << i);
			rd(A_SB, 32'h0000_0000);
			pins(1'b0, 1'b1, 1'b0);
		end
		$display("logging test done");
	endtask : t_log

	task t_ctrl;
		logic [2:0]  c [3] = '{3'b110, 3'b101, 3'b100};
		logic [31:0] e [3] = '{32'h0000_0006, 32'h0000_0002, 32'h0000_0008};
		for (int k = 0; k < 3; k++) begin
			fire(10'h000, 9'h000, c[k]);
			rd(A_SB, e[k]);
			wr(A_SB, 32'h0000_03FF);
		end
		$display("control char test done");
	endtask : t_ctrl

	task t_mask;
		wr(A_EN, 32'h0000_0000);
		fire(10'h240, 9'h000, 3'h0);
		rd(A_SB, 32'h0000_0240);
		pins(1'b0, 1'b1, 1'b0);
		wr(A_EN, 32'h0010_0000);
		rd(A_EN, 32'h0010_0000);
		pins(1'b1, 1'b1, 1'b0);
		wr(A_EN, 32'hFFFF_FFFF);
		rd(A_EN, rxeil_pkg::IRQ_EN_MASK);
		wr(A_SB, 32'h0000_03FF);
		wr(A_EN, rxeil_pkg::IRQ_EN_RESET);
		$display("mask test done");
	endtask : t_mask

	task t_reinit;
		fire(10'h002, 9'h000, 3'h0);
		pins(1'b1, 1'b1, 1'b1);
		wr(A_RI, 32'h0010_0000);
		fire(10'h200, 9'h000, 3'h0);
		pins(1'b1, 1'b0, 1'b1);
		wr(A_SB, 32'h0000_03FF);
		rd(A_SB, 32'h0000_0000);
		pins(1'b0, 1'b1, 1'b0);
		wr(A_RI, 32'h0000_0000);
		fire(10'h001, 9'h000, 3'h0);
		pins(1'b1, 1'b0, 1'b0);
		wr(A_SB, 32'h0000_0001);
		rd(A_SB, 32'h0000_0000);
		pins(1'b0, 1'b1, 1'b0);
		wr(A_RI, rxeil_pkg::REINIT_RESET);
		$display("reinit test done");
	endtask : t_reinit

	task t_sel;
		fire(10'h202, 9'h002, 3'h0);
		wb(1'b1, A_SB, 32'h0000_0202, 4'b0001);
		rd(A_SB, 32'h0000_0200);
		rd(A_SA, 32'h0000_0002);
		wr(A_SB, 32'h0000_0200);
		pins(1'b1, 1'b0, 1'b0);
		wr(A_SA, 32'h0000_01FE);
		rd(A_SA, 32'h0000_0000);
		pins(1'b0, 1'b1, 1'b0);
		$display("byte lane test done");
	endtask : t_sel

	initial begin
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_log();
		t_ctrl();
		t_mask();
		t_reinit();
		t_sel();
		give_verdict();
	end
endmodule : rxeil_top_tb
`default_nettype wire
